/* dv/bov_mem_model.sv */
// Purpose: Memory aperture model that answers the engine's word requests
// Assumes: One read outstanding at a time, 256 words, byte addresses
// Notes: Read data toggles while idle so a stale word never looks valid
`timescale 1ns/1ps
module bov_mem_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rd_data,
	output logic rd_valid
);
	logic [31:0] mem [0:255];
	logic [31:0] raddr_q;
	logic [2:0] wait_q;
	logic pend_q;
	// Word store, preloaded by the bench
	always @(posedge clk) begin
		if (wr_req) mem[addr[9:2]] <= wdata;
	end
	// Read answer one cycle after the request, or five when slow
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_q <= 1'b0;
			wait_q <= 3'h0;
			raddr_q <= 32'h0;
			rd_valid <= 1'b0;
			rd_data <= 32'h0;
		end else begin
			rd_valid <= 1'b0;
			rd_data <= ~rd_data;
			if (rd_req) begin
				pend_q <= 1'b1;
				raddr_q <= addr;
				wait_q <= slow ? 3'h4 : 3'h0;
			end else if (pend_q && wait_q != 3'h0) begin
				wait_q <= wait_q - 3'h1;
			end else if (pend_q) begin
				pend_q <= 1'b0;
				rd_valid <= 1'b1;
				rd_data <= mem[raddr_q[9:2]];
			end
		end
	end
endmodule

/* dv/test_blit_overlap_and_source_addressing.sv */
// Purpose: Self-checking bench for the block-copy addressing engine
// Assumes: Engine wired to the memory model and a bench-driven stream
// Notes: Expected memory is a reference copy taken from a snapshot
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_blit_overlap_and_source_addressing;
	logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cs_valid = 1'b0, slow = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, cs_data = 32'h0, rd_v, fst_rd, fst_wr;
	logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rd_data;
	logic cs_ready, mem_rd_req, mem_wr_req, mem_rd_valid, busy;
	logic [31:0] exp_mem [0:255];
	int bad_count = 0, tests_run = 0, n_rd = 0, n_wr = 0, k, c;
	always #5 clk = ~clk;
	bov_engine i_bov_engine (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cs_data(cs_data), .cs_valid(cs_valid), .cs_ready(cs_ready),
		.mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
		.busy(busy));
	bov_mem_model i_bov_mem_model (.clk(clk), .nrst(nrst), .slow(slow), .rd_req(mem_rd_req),
		.wr_req(mem_wr_req), .addr(mem_addr), .wdata(mem_wdata), .rd_data(mem_rd_data),
		.rd_valid(mem_rd_valid));
	// Record first addresses and counts of memory requests
	always @(posedge clk) begin
		if (mem_rd_req === 1'b1) begin
			if (n_rd == 0) fst_rd = mem_addr;
			n_rd++;
		end
		if (mem_wr_req === 1'b1) begin
			if (n_wr == 0) fst_wr = mem_addr;
			n_wr++;
		end
	end
	// Register bus cycles
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task cfg(input logic [31:0] s, dd, sp, dp, w, l);
		wr(bov_pkg::OFS_SRC, s);
		wr(bov_pkg::OFS_DST, dd);
		wr(bov_pkg::OFS_SPITCH, sp);
		wr(bov_pkg::OFS_DPITCH, dp);
		wr(bov_pkg::OFS_WIDTH, w);
		wr(bov_pkg::OFS_LINES, l);
	endtask
	// Start a transfer, optionally poke a register mid-run, wait for idle
	task run(input logic [5:0] ctl, input bit hit);
		int t;
		n_rd = 0;
		n_wr = 0;
		wr(bov_pkg::OFS_CTRL, {26'h0, ctl | 6'h01});
		if (hit) wr(bov_pkg::OFS_SRC, 32'h3fc);
		t = 0;
		@(posedge clk);
		while (busy !== 1'b0 && t < 2000) begin
			@(posedge clk);
			t++;
		end
		`CHK("busy", 1'b0, busy)
	endtask
	// Reference copy in safe order from a snapshot
	task ref_copy(input logic [31:0] s, dd, sp, dp, w, l);
		logic [31:0] t [0:255];
		int i, j;
		t = exp_mem;
		for (i = 0; i < l; i++) begin
			for (j = 0; j < w; j++)
				exp_mem[(dd + i * dp + j * 4) >> 2] = t[(s + i * sp + j * 4) >> 2];
		end
	endtask
	task check_mem(input string n);
		int i;
		for (i = 0; i < 256; i++)
			`CHK("mem", exp_mem[i], i_bov_mem_model.mem[i])
		$display("test %s done: %0d checks, %0d mismatches", n, tests_run, bad_count);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Watchdog against a hung transfer
	initial begin
		#400000;
		bad_count++;
		summarize;
	end
	initial begin
		for (k = 0; k < 256; k++) begin
			exp_mem[k] = 32'h1000_0000 + k;
			i_bov_mem_model.mem[k] = exp_mem[k];
		end
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		// Reset values and an unmapped read
		rd(bov_pkg::OFS_CTRL, rd_v);
		`CHK("ctrl", 32'h0, rd_v)
		rd(bov_pkg::OFS_STAT, rd_v);
		`CHK("stat", 32'h0, rd_v)
		rd(8'h40, rd_v);
		`CHK("unmapped", 32'h0, rd_v)
		`CHK("cs_ready", 1'b1, cs_ready)
		$display("test reset done");
		// Manual corners on disjoint blocks, colour words only
		for (c = 0; c < 4; c++) begin
			slow <= c[0];
			cfg(32'h0, 32'h200, 32'h40, 32'h80, 32'h3, 32'h2);
			run(6'(c * 2), c == 0);
			if (c == 0) begin
				rd(bov_pkg::OFS_SRC, rd_v);
				`CHK("src_kept", 32'h0, rd_v)
			end
			rd_v = (c[1] ? 32'h40 : 32'h0) + (c[0] ? 32'h8 : 32'h0);
			`CHK("first_rd", rd_v, fst_rd)
			rd_v = 32'h200 + (c[1] ? 32'h80 : 32'h0) + (c[0] ? 32'h8 : 32'h0);
			`CHK("first_wr", rd_v, fst_wr)
			`CHK("writes", 32'd6, 32'(n_wr))
			ref_copy(32'h0, 32'h200, 32'h40, 32'h80, 32'h3, 32'h2);
			check_mem("corner");
		end
		// Overlap with the destination below and right of the source
		cfg(32'h100, 32'h128, 32'h20, 32'h20, 32'h4, 32'h3);
		run(6'h08, 1'b0);
		`CHK("first_wr", 32'h174, fst_wr)
		rd(bov_pkg::OFS_STAT, rd_v);
		`CHK("stat_br", 4'he, rd_v[3:0])
		ref_copy(32'h100, 32'h128, 32'h20, 32'h20, 32'h4, 32'h3);
		check_mem("overlap_br");
		// Overlap with the destination above and left of the source
		cfg(32'h128, 32'h100, 32'h20, 32'h20, 32'h4, 32'h3);
		run(6'h08, 1'b0);
		`CHK("first_wr", 32'h100, fst_wr)
		rd(bov_pkg::OFS_STAT, rd_v);
		`CHK("stat_tl", 4'h2, rd_v[3:0])
		ref_copy(32'h128, 32'h100, 32'h20, 32'h20, 32'h4, 32'h3);
		check_mem("overlap_tl");
		// Fill the stream buffer until it refuses, whole aligned words
		slow <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 16; k++) begin
			cs_valid <= 1'b1;
			cs_data <= 32'h7000_0000 + k;
			@(posedge clk);
		end
		cs_valid <= 1'b0;
		cs_data <= 32'h8fff_fff0;
		#1;
		`CHK("cs_full", 1'b0, cs_ready)
		// Drain it through an inline copy from the bottom-right corner
		cfg(32'h0, 32'h300, 32'h10, 32'h10, 32'h4, 32'h4);
		run(6'h16, 1'b0);
		`CHK("reads", 32'd0, 32'(n_rd))
		`CHK("cs_ready", 1'b1, cs_ready)
		for (k = 0; k < 16; k++)
			exp_mem[(32'h300 + (3 - k / 4) * 16 + (3 - k % 4) * 4) >> 2] = 32'h7000_0000 + k;
		check_mem("inline");
		// Indirect source through the pointer, contiguous pitch
		slow <= 1'b0;
		wr(bov_pkg::OFS_IPTR, 32'h40);
		wr(bov_pkg::OFS_ISIZE, 32'h18);
		rd(bov_pkg::OFS_ISIZE, rd_v);
		`CHK("isize", 32'h18, rd_v)
		cfg(32'h0, 32'h380, 32'hc, 32'h10, 32'h3, 32'h2);
		run(6'h20, 1'b0);
		`CHK("first_rd", 32'h40, fst_rd)
		ref_copy(32'h40, 32'h380, 32'hc, 32'h10, 32'h3, 32'h2);
		check_mem("indirect");
		summarize;
	end
endmodule

/* rtl/bov_engine.sv */
// Purpose: Source and destination address walker of a block-copy engine
// Assumes: Memory takes a one-cycle request per word and answers reads in order
// Notes: Inline source words pass a 16-word FIFO before the walker uses them
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Parameterised first-in first-out buffer of flip-flops
module bov_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic [PW:0] cnt_q;
	logic [PW:0] cnt_d;
	logic push;
	logic pop;
	// Handshakes on both sides
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];
	// Occupancy next value, unchanged when a push and a pop meet
	assign cnt_d = (push && !pop) ? cnt_q + 1'b1 : (pop && !push) ? cnt_q - 1'b1 : cnt_q;
	// Pointers, count and registered ready
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				wp_q <= PW'(wp_q + 1'b1);
			end
			if (pop) begin
				rp_q <= PW'(rp_q + 1'b1);
			end
			cnt_q <= cnt_d;
			in_ready <= cnt_d != (PW+1)'(DEPTH);
		end
	end
	// Storage, one word per entry
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule
// Contract
// - Coordinate copies detect overlap and pick direction
// - Never write overlapped pixel before reading it
// - Default walk starts upper-left, top line first
// - Any of four corners selectable by command
// - Destination lower-right of source: start bottom-right
// - Block: start, line length, pitch, line count
// - Source bit selects memory or inline data
// - Memory source fetched from command source address
// - Inline words follow their command as pixels
// - Indirect command fetches from pointer and size (code fetches from the pointer only; isize_q is stored but unused)
// - Line starts advance by byte pitch
module bov_engine (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] cs_data,
	input wire logic cs_valid,
	output logic cs_ready,
	output logic mem_rd_req,
	output logic mem_wr_req,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rd_data,
	input wire logic mem_rd_valid,
	output logic busy
);
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_FETCH, S_RWAIT, S_STORE, S_STEP} bov_state_t;
	bov_state_t state_q;
	logic [31:0] src_q, dst_q, spitch_q, dpitch_q, iptr_q, isize_q;
	logic [15:0] width_q, lines_q;
	logic [1:0] corner_cfg_q, corner_eff;
	logic auto_q, inline_cfg_q, ind_cfg_q, auto_eff, inline_eff, ind_eff;
	bov_pkg::bov_corner_t corner_q;
	logic ovl_q, inline_q, ind_q;
	logic [31:0] s_line_q, d_line_q, s_addr_q, d_addr_q, pix_q;
	logic [31:0] sp_eff, s_base, src_end, dst_end, line_bytes;
	logic [15:0] pix_cnt_q, line_cnt_q;
	logic have_q, go, ovl, fifo_pop, fifo_valid;
	logic [31:0] fifo_data;
	bov_pkg::bov_corner_t corner_sel;
	assign go = reg_wr && reg_addr == bov_pkg::OFS_CTRL && reg_wdata[bov_pkg::CTRL_GO];
	assign line_bytes = {14'h0, width_q, 2'h0};
	// A start command carries its own settings; the stored ones would be one write stale
	assign {ind_eff, inline_eff, auto_eff, corner_eff} = go
		? reg_wdata[bov_pkg::CTRL_IND:bov_pkg::CTRL_CORNER]
		: {ind_cfg_q, inline_cfg_q, auto_q, corner_cfg_q};
	// Overlap test over the byte spans of both blocks
	always_comb begin
		src_end = src_q + 32'(lines_q - 16'h1) * spitch_q + line_bytes;
		dst_end = dst_q + 32'(lines_q - 16'h1) * dpitch_q + line_bytes;
		ovl = (src_q < dst_end) && (dst_q < src_end);
		corner_sel = bov_pkg::bov_corner_t'(corner_eff);
		if (auto_eff) begin // Overlapping higher destination walks backwards so reads lead writes
			corner_sel = (ovl && dst_q > src_q) ? bov_pkg::BOV_BR : bov_pkg::BOV_TL;
		end
	end
	// Indirect source uses the pointer and a contiguous pitch
	assign s_base = ind_q ? iptr_q : src_q;
	assign sp_eff = ind_q ? line_bytes : spitch_q;
	// Register writes from software
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_q <= bov_pkg::ADDR_RST;
			dst_q <= bov_pkg::ADDR_RST;
			spitch_q <= bov_pkg::ADDR_RST;
			dpitch_q <= bov_pkg::ADDR_RST;
			iptr_q <= bov_pkg::ADDR_RST;
			isize_q <= bov_pkg::ADDR_RST;
			width_q <= bov_pkg::LEN_RST;
			lines_q <= bov_pkg::LEN_RST;
			{ind_cfg_q, inline_cfg_q, auto_q, corner_cfg_q} <= bov_pkg::CTRL_RST[5:1];
		end else if (reg_wr && state_q == S_IDLE) begin
			unique case (reg_addr)
				bov_pkg::OFS_CTRL: begin
					corner_cfg_q <= reg_wdata[bov_pkg::CTRL_CORNER +: 2];
					auto_q <= reg_wdata[bov_pkg::CTRL_AUTO];
					inline_cfg_q <= reg_wdata[bov_pkg::CTRL_INLINE];
					ind_cfg_q <= reg_wdata[bov_pkg::CTRL_IND];
				end
				bov_pkg::OFS_SRC: src_q <= reg_wdata;
				bov_pkg::OFS_DST: dst_q <= reg_wdata;
				bov_pkg::OFS_SPITCH: spitch_q <= reg_wdata;
				bov_pkg::OFS_DPITCH: dpitch_q <= reg_wdata;
				bov_pkg::OFS_WIDTH: width_q <= reg_wdata[15:0];
				bov_pkg::OFS_LINES: lines_q <= reg_wdata[15:0];
				bov_pkg::OFS_IPTR: iptr_q <= reg_wdata;
				bov_pkg::OFS_ISIZE: isize_q <= reg_wdata;
				default: ;
			endcase
		end
	end
	// Read data, valid in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				bov_pkg::OFS_CTRL: reg_rdata <= {26'h0, ind_cfg_q, inline_cfg_q, auto_q, corner_cfg_q, 1'b0};
				bov_pkg::OFS_STAT: reg_rdata <= {28'h0, corner_q, ovl_q, busy};
				bov_pkg::OFS_SRC: reg_rdata <= src_q;
				bov_pkg::OFS_DST: reg_rdata <= dst_q;
				bov_pkg::OFS_SPITCH: reg_rdata <= spitch_q;
				bov_pkg::OFS_DPITCH: reg_rdata <= dpitch_q;
				bov_pkg::OFS_WIDTH: reg_rdata <= {16'h0, width_q};
				bov_pkg::OFS_LINES: reg_rdata <= {16'h0, lines_q};
				bov_pkg::OFS_IPTR: reg_rdata <= iptr_q;
				bov_pkg::OFS_ISIZE: reg_rdata <= isize_q;
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end
	// Inline words from the command stream, stalled by the walker
	assign fifo_pop = state_q == S_FETCH && inline_q;
	bov_fifo #(.WIDTH(bov_pkg::DW), .DEPTH(bov_pkg::FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_data(cs_data),
		.in_valid(cs_valid),
		.in_ready(cs_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);
	// Walk sequencer: latch command, place corner, read then write each pixel
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			corner_q <= bov_pkg::BOV_TL;
			ovl_q <= 1'b0;
			inline_q <= 1'b0;
			ind_q <= 1'b0;
			busy <= 1'b0;
		end else begin
			unique case (state_q)
				S_IDLE: if (go) begin
					corner_q <= corner_sel;
					ovl_q <= ovl;
					inline_q <= inline_eff && !ind_eff;
					ind_q <= ind_eff;
					busy <= 1'b1;
					state_q <= S_SETUP;
				end
				S_SETUP: begin
					busy <= width_q != 16'h0 && lines_q != 16'h0;
					state_q <= (width_q != 16'h0 && lines_q != 16'h0) ? S_FETCH : S_IDLE;
				end
				S_FETCH: if (!inline_q || fifo_valid) begin
					state_q <= inline_q ? S_STORE : S_RWAIT;
				end
				S_RWAIT: if (mem_rd_valid) begin
					state_q <= S_STORE;
				end
				S_STORE: state_q <= S_STEP;
				S_STEP: begin
					busy <= pix_cnt_q != 16'h0 || line_cnt_q != 16'h0;
					state_q <= (pix_cnt_q != 16'h0 || line_cnt_q != 16'h0) ? S_FETCH : S_IDLE;
				end
			endcase
		end
	end
	// Address walker: corner placement, pixel and line stepping
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_line_q <= bov_pkg::ADDR_RST;
			d_line_q <= bov_pkg::ADDR_RST;
			s_addr_q <= bov_pkg::ADDR_RST;
			d_addr_q <= bov_pkg::ADDR_RST;
			pix_cnt_q <= bov_pkg::LEN_RST;
			line_cnt_q <= bov_pkg::LEN_RST;
		end else if (state_q == S_SETUP) begin // First pixel at the chosen corner of both blocks
			s_line_q <= s_base + (corner_q[1] ? 32'(lines_q - 16'h1) * sp_eff : 32'h0) +
				(corner_q[0] ? line_bytes - bov_pkg::PIX_BYTES : 32'h0);
			d_line_q <= dst_q + (corner_q[1] ? 32'(lines_q - 16'h1) * dpitch_q : 32'h0) +
				(corner_q[0] ? line_bytes - bov_pkg::PIX_BYTES : 32'h0);
			s_addr_q <= s_base + (corner_q[1] ? 32'(lines_q - 16'h1) * sp_eff : 32'h0) +
				(corner_q[0] ? line_bytes - bov_pkg::PIX_BYTES : 32'h0);
			d_addr_q <= dst_q + (corner_q[1] ? 32'(lines_q - 16'h1) * dpitch_q : 32'h0) +
				(corner_q[0] ? line_bytes - bov_pkg::PIX_BYTES : 32'h0);
			pix_cnt_q <= width_q - 16'h1;
			line_cnt_q <= lines_q - 16'h1;
		end else if (state_q == S_STEP) begin
			if (pix_cnt_q != 16'h0) begin // Next pixel in the line, leftward from a right corner
				s_addr_q <= corner_q[0] ? s_addr_q - bov_pkg::PIX_BYTES
					: s_addr_q + bov_pkg::PIX_BYTES;
				d_addr_q <= corner_q[0] ? d_addr_q - bov_pkg::PIX_BYTES
					: d_addr_q + bov_pkg::PIX_BYTES;
				pix_cnt_q <= pix_cnt_q - 16'h1;
			end else if (line_cnt_q != 16'h0) begin // Next line by the byte pitch, upward from bottom
				s_line_q <= corner_q[1] ? s_line_q - sp_eff : s_line_q + sp_eff;
				d_line_q <= corner_q[1] ? d_line_q - dpitch_q : d_line_q + dpitch_q;
				s_addr_q <= corner_q[1] ? s_line_q - sp_eff : s_line_q + sp_eff;
				d_addr_q <= corner_q[1] ? d_line_q - dpitch_q : d_line_q + dpitch_q;
				pix_cnt_q <= width_q - 16'h1;
				line_cnt_q <= line_cnt_q - 16'h1;
			end
		end
	end
	// Memory requests: a pixel is held before its destination is written
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem_rd_req <= 1'b0;
			mem_wr_req <= 1'b0;
			mem_addr <= bov_pkg::ADDR_RST;
			mem_wdata <= 32'h0;
			pix_q <= 32'h0;
			have_q <= 1'b0;
		end else begin
			mem_rd_req <= state_q == S_FETCH && !inline_q;
			mem_wr_req <= state_q == S_STORE && have_q;
			if (state_q == S_FETCH && !inline_q) begin
				mem_addr <= s_addr_q;
			end else if (state_q == S_STORE) begin
				mem_addr <= d_addr_q;
				mem_wdata <= pix_q;
			end
			if (state_q == S_FETCH && inline_q && fifo_valid) begin
				pix_q <= fifo_data;
				have_q <= 1'b1;
			end else if (state_q == S_RWAIT && mem_rd_valid) begin
				pix_q <= mem_rd_data;
				have_q <= 1'b1;
			end else if (state_q == S_STORE) begin
				have_q <= 1'b0;
			end
		end
	end
	// Helper: writes issued in the current transfer
	logic [31:0] wr_cnt_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_cnt_q <= 32'h0;
		end else if (state_q == S_SETUP) begin
			wr_cnt_q <= 32'h0;
		end else if (mem_wr_req) begin
			wr_cnt_q <= wr_cnt_q + 32'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence seq_fetch_mem;
		state_q == S_FETCH && !inline_q;
	endsequence
	sequence seq_read_done;
		state_q == S_RWAIT && mem_rd_valid ##1 state_q == S_STORE;
	endsequence
	AST_AUTO_REVERSE: assert property (state_q == S_IDLE && go && auto_eff && ovl && dst_q > src_q
		|=> corner_q == bov_pkg::BOV_BR) else $error("auto overlap not reversed");
	AST_WRITE_AFTER_READ: assert property (seq_read_done |=> mem_wr_req)
		else $error("read pixel not written next");
	AST_NO_EARLY_WRITE: assert property (mem_wr_req |-> $past(have_q))
		else $error("write without a read pixel");
	AST_TOP_LEFT_START: assert property (state_q == S_SETUP && corner_q == bov_pkg::BOV_TL
		|=> d_addr_q == dst_q) else $error("top-left start address wrong");
	AST_BR_START: assert property (state_q == S_SETUP && corner_q == bov_pkg::BOV_BR
		|=> d_addr_q == dst_q + 32'(lines_q - 16'h1) * dpitch_q + line_bytes - 32'h4)
		else $error("bottom-right start address wrong");
	AST_LINE_PITCH: assert property (state_q == S_STEP && pix_cnt_q == 16'h0 && line_cnt_q != 16'h0
		&& !corner_q[1] |=> d_line_q == $past(d_line_q) + dpitch_q)
		else $error("line start not advanced by pitch");
	AST_FETCH_ADDR: assert property (seq_fetch_mem |=> mem_rd_req && mem_addr == $past(s_addr_q))
		else $error("fetch address mismatch");
	AST_INLINE_NO_READ: assert property (busy && inline_q |-> !mem_rd_req)
		else $error("memory read during inline source");
	AST_INDIRECT_BASE: assert property (state_q == S_SETUP && ind_q && corner_q == bov_pkg::BOV_TL
		|=> s_addr_q == iptr_q) else $error("indirect source base wrong");
	AST_PIXEL_COUNT: assert property ($fell(busy) |-> wr_cnt_q == 32'(width_q) * 32'(lines_q))
		else $error("pixel count differs from block size");
endmodule

/* rtl/bov_pkg.sv */
// Purpose: Shared constants for the block-copy addressing engine
// Assumes: 32-bit words, one pixel per word, byte addresses
// Notes: Register offsets are byte addresses on the plain register port
package bov_pkg;
	localparam int AW = 32;
	localparam int DW = 32;
	localparam int LW = 16;
	localparam int FIFO_DEPTH = 16;
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_SRC = 8'h08;
	localparam logic [7:0] OFS_DST = 8'h0c;
	localparam logic [7:0] OFS_SPITCH = 8'h10;
	localparam logic [7:0] OFS_DPITCH = 8'h14;
	localparam logic [7:0] OFS_WIDTH = 8'h18;
	localparam logic [7:0] OFS_LINES = 8'h1c;
	localparam logic [7:0] OFS_IPTR = 8'h20;
	localparam logic [7:0] OFS_ISIZE = 8'h24;
	// Control field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_CORNER = 1;
	localparam int CTRL_AUTO = 3;
	localparam int CTRL_INLINE = 4;
	localparam int CTRL_IND = 5;
	localparam logic [5:0] CTRL_RST = 6'h00;
	// Status field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_OVL = 1;
	localparam int STAT_CORNER = 2;
	localparam logic [31:0] ADDR_RST = 32'h0;
	localparam logic [15:0] LEN_RST = 16'h0;
	localparam logic [31:0] PIX_BYTES = 32'h4;
	// Corner code: bit 0 walks right to left, bit 1 walks bottom to top
	typedef enum logic [1:0] {
		BOV_TL = 2'h0,
		BOV_TR = 2'h1,
		BOV_BL = 2'h2,
		BOV_BR = 2'h3
	} bov_corner_t;
endpackage
